/* File: csc_regs.vh */
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
// ********************************
// Register offsets
// ********************************
`define CSC_ADDR_CTRL     4'h0
`define CSC_ADDR_PULSE    4'h1
`define CSC_ADDR_LIMIT    4'h2
`define CSC_ADDR_STATUS   4'h3
`define CSC_ADDR_FAULT    4'h4
// ********************************
// Control register bits
// ********************************
`define CSC_CTRL_OFF      0
`define CSC_CTRL_DLY      1
`define CSC_CTRL_RSTEN    2
`define CSC_CTRL_REGRST   3
`define CSC_CTRL_BOOST    4
`define CSC_CTRL_LIMPIN   5
`define CSC_CTRL_RESET    8'h04
// ********************************
// Pulse register bits
// ********************************
`define CSC_PUL_EN        0
`define CSC_PUL_UP        1
`define CSC_PUL_DN        2
// ********************************
// Charge fault codes
// ********************************
`define CSC_CF_NONE       2'h0
`define CSC_CF_INOV       2'h1
`define CSC_CF_THERM      2'h2
`define CSC_LIM_100MA     6'h00
// ********************************
// Times
// ********************************
`define CSC_CLK_MHZ       250
`define CSC_INT_US        256
`define CSC_DEGL_US       1000
`define CSC_HOLD_MS       15000
`define CSC_RSTOFF_MS     250
`define CSC_SMDLY_MS      10000
`define CSC_PULSE_MS      100
`define CSC_PULSE_NUM     4'h8
`endif

/* File: csc_top.v */
// How it works
// - Each event while no pulse is running makes one interrupt pulse lasting 256 us.
// - Events: source identified, good input, input removed, charge done, input overvoltage, thermal shutdown or other fault.
// - Fault pulses interrupt and stays latched until the fault register is read.
// - No new fault interrupt while latched faults remain unread.
// - First fault read gives latched status, second read gives only faults newly raised since the first.
// - Switch-off bit opens battery switch now or after a delay per delay bit.
// - Ship mode exits on adapter, bit clear, register reset, or button press.
// - Button held low 15 s without input opens switch briefly, then closes.
// - Button power reset is inhibited when its enable bit is zero.
// - Running sequence shows its request bit and toggles limit with 100 mA.
// - Sequence end restores configured limit and clears the request bit.
// - Clearing protocol enable aborts sequence and restores limit at once.
// - Down request writes are ignored while protocol enable is low.
// - Pin limit enabled: lower of pin and register; disabled: pin unused.
// - Over regulation threshold: cut current, no termination, half timer, flag.
// - Buck thermal shutdown stops converter and switch, fault code 10, interrupt.
// - Boost thermal shutdown clears boost bit and opens switch until cool.
// - Input overvoltage stops switching, fault code 01, interrupt.
// - System overvoltage stops the converter at once.
// - Thermistor fault field is never latched, always live.
`include "csc_regs.vh"
module csc_top #(
  parameter INT_CYC    = `CSC_INT_US * `CSC_CLK_MHZ,
  parameter DEGL_CYC   = `CSC_DEGL_US * `CSC_CLK_MHZ,
  parameter HOLD_CYC   = 64'd15000 * 64'd1000 * `CSC_CLK_MHZ,
  parameter RSTOFF_CYC = 64'd250 * 64'd1000 * `CSC_CLK_MHZ,
  parameter SMDLY_CYC  = 64'd10000 * 64'd1000 * `CSC_CLK_MHZ,
  parameter PULSE_CYC  = 64'd100 * 64'd1000 * `CSC_CLK_MHZ,
  parameter CW         = 32
) (
  // Clock and reset
  input  wire       MCLK,
  input  wire       RST_B,
  // Register port
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Power stage status
  input  wire       SRC_ID,
  input  wire       GOOD_IN,
  input  wire       IN_REMOVED,
  input  wire       CHG_DONE,
  input  wire       VBUS_PRESENT,
  input  wire       PUSH_BUTTON_INPUT_B,
  input  wire       INPUT_OVERVOLTAGE,
  input  wire       SYSTEM_OVERVOLTAGE,
  input  wire       TSHUT,
  input  wire       OVER_THERMAL_REGULATION_THRESHOLD,
  input  wire [2:0] THERMISTOR_FAULT_FIELD,
  input  wire       OTHER_FAULT,
  input  wire       BOOST_MODE,
  input  wire [5:0] INPUT_LIMIT_SETTING,
  input  wire [5:0] CURRENT_LIMIT_PIN,
  // Power stage control
  output reg        HOST_INT_B,
  output reg        BATTERY_SWITCH,
  output reg        CONVERTER_EN,
  output reg  [5:0] CURRENT_LIMIT_PIN_EFF,
  output reg        CHG_REDUCE,
  output reg        TERM_DIS,
  output reg        TIMER_HALF
);
  // ********************************
  // Helpers
  // ********************************
  function [5:0] min6;
    input [5:0] a;
    input [5:0] b;
    begin
      min6 = (a < b) ? a : b;
    end
  endfunction

  localparam [CW-1:0] INT_N    = INT_CYC[CW-1:0];
  localparam [CW-1:0] DEGL_N   = DEGL_CYC[CW-1:0];
  localparam [CW-1:0] HOLD_N   = HOLD_CYC[CW-1:0];
  localparam [CW-1:0] RSTOFF_N = RSTOFF_CYC[CW-1:0];
  localparam [CW-1:0] SMDLY_N  = SMDLY_CYC[CW-1:0];
  localparam [CW-1:0] PULSE_N  = PULSE_CYC[CW-1:0];
  localparam [CW-1:0] ONE      = 1;
  localparam [CW-1:0] ZERO     = 0;

  localparam [1:0] SW_ON   = 2'h0;
  localparam [1:0] SW_DLY  = 2'h1;
  localparam [1:0] SW_SHIP = 2'h2;
  localparam [1:0] SW_RST  = 2'h3;

  wire wr_ctrl  = WR && (ADDR == `CSC_ADDR_CTRL);
  wire wr_pul   = WR && (ADDR == `CSC_ADDR_PULSE);
  wire rd_fault = RD && (ADDR == `CSC_ADDR_FAULT);
  wire regrst   = wr_ctrl && WDATA[`CSC_CTRL_REGRST];
  wire ship_wake;

  // ********************************
  // Control register
  // ********************************
  reg [7:0] ctrl_q;
  reg       boost_q;
  always @(posedge MCLK)
  begin
    if (!RST_B || regrst)
    begin
      ctrl_q  <= `CSC_CTRL_RESET;
      boost_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= WDATA;
      else if (ship_wake)
        ctrl_q[`CSC_CTRL_OFF] <= 1'b0;
      if (BOOST_MODE && TSHUT)
        boost_q <= 1'b0;
      else if (wr_ctrl)
        boost_q <= WDATA[`CSC_CTRL_BOOST];
    end
  end
  wire off_bit = ctrl_q[`CSC_CTRL_OFF];

  // ********************************
  // Fault latch
  // ********************************
  wire [1:0] cf_live = TSHUT && !BOOST_MODE ? `CSC_CF_THERM :
                       INPUT_OVERVOLTAGE ? `CSC_CF_INOV : `CSC_CF_NONE;
  wire [3:0] f_live  = {OTHER_FAULT, BOOST_MODE && TSHUT, cf_live};
  reg  [3:0] f_lat_q;
  reg  [3:0] f_prev_q;
  wire       f_new   = |(f_live & ~f_prev_q);
  wire       latched = |f_lat_q;
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      f_lat_q  <= 4'h0;
      f_prev_q <= 4'h0;
    end
    else
    begin
      f_prev_q <= f_live;
      if (rd_fault)
        f_lat_q <= f_live & ~f_prev_q; // new event set wins
      else
        f_lat_q <= f_lat_q | (f_live & ~f_prev_q);
    end
  end

  // ********************************
  // Interrupt pulse
  // ********************************
  reg [CW-1:0] int_cnt_q;
  wire ev = SRC_ID || GOOD_IN || IN_REMOVED || CHG_DONE || (f_new && !latched);
  always @(posedge MCLK)
  begin
    if (!RST_B)
      int_cnt_q <= ZERO;
    else if (int_cnt_q != ZERO)
      int_cnt_q <= int_cnt_q - ONE;
    else if (ev)
      int_cnt_q <= INT_N;
  end
  always @(posedge MCLK)
  begin
    if (!RST_B)
      HOST_INT_B <= 1'b1;
    else
      HOST_INT_B <= !((int_cnt_q > ONE) || (int_cnt_q == ZERO && ev));
  end

  // ********************************
  // Push button deglitch
  // ********************************
  reg [CW-1:0] degl_q;
  reg          btn_q;
  reg          btn_fall_q;
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      degl_q     <= ZERO;
      btn_q      <= 1'b1;
      btn_fall_q <= 1'b0;
    end
    else
    begin
      btn_fall_q <= 1'b0;
      if (PUSH_BUTTON_INPUT_B == btn_q)
        degl_q <= ZERO;
      else if (degl_q >= DEGL_N - ONE)
      begin
        degl_q     <= ZERO;
        btn_q      <= PUSH_BUTTON_INPUT_B;
        btn_fall_q <= btn_q;
      end
      else
        degl_q <= degl_q + ONE;
    end
  end

  // ********************************
  // Battery switch
  // ********************************
  reg [1:0]    sw_q;
  reg [CW-1:0] sw_cnt_q;
  reg [CW-1:0] hold_q;
  // Wake from ship mode also drops the off bit so it is not re-entered
  assign ship_wake = (sw_q == SW_SHIP) && (VBUS_PRESENT || btn_fall_q);
  always @(posedge MCLK)
  begin
    if (!RST_B)
      hold_q <= ZERO;
    else if (btn_q || VBUS_PRESENT || off_bit || !ctrl_q[`CSC_CTRL_RSTEN] || sw_q != SW_ON)
      hold_q <= ZERO;
    else if (hold_q != HOLD_N)
      hold_q <= hold_q + ONE;
  end
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      sw_q     <= SW_ON;
      sw_cnt_q <= ZERO;
    end
    else
    begin
      case (sw_q)
        SW_ON:
        begin
          sw_cnt_q <= ZERO;
          if (off_bit)
            sw_q <= ctrl_q[`CSC_CTRL_DLY] ? SW_DLY : SW_SHIP;
          else if (hold_q == HOLD_N)
            sw_q <= SW_RST;
        end
        SW_DLY:
        begin
          sw_cnt_q <= sw_cnt_q + ONE;
          if (!off_bit)
            sw_q <= SW_ON;
          else if (sw_cnt_q >= SMDLY_N - ONE)
            sw_q <= SW_SHIP;
        end
        SW_SHIP:
        begin
          if (VBUS_PRESENT || !off_bit || btn_fall_q)
            sw_q <= SW_ON;
        end
        SW_RST:
        begin
          sw_cnt_q <= sw_cnt_q + ONE;
          if (sw_cnt_q >= RSTOFF_N - ONE)
            sw_q <= SW_ON;
        end
        default:
          sw_q <= SW_ON;
      endcase
    end
  end

  // ********************************
  // Current pulse sequencer
  // ********************************
  reg          pen_q;
  reg          up_q;
  reg          dn_q;
  reg [CW-1:0] pcnt_q;
  reg [3:0]    pnum_q;
  wire         run = up_q || dn_q;
  always @(posedge MCLK)
  begin
    if (!RST_B || regrst)
    begin
      pen_q  <= 1'b0;
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      pcnt_q <= ZERO;
      pnum_q <= 4'h0;
    end
    else
    begin
      if (wr_pul)
        pen_q <= WDATA[`CSC_PUL_EN];
      if (wr_pul && !WDATA[`CSC_PUL_EN])
      begin
        up_q <= 1'b0;
        dn_q <= 1'b0;
      end
      else if (!run)
      begin
        pcnt_q <= ZERO;
        pnum_q <= 4'h0;
        if (wr_pul && pen_q && (WDATA[`CSC_PUL_UP] ^ WDATA[`CSC_PUL_DN]))
        begin
          up_q <= WDATA[`CSC_PUL_UP];
          dn_q <= WDATA[`CSC_PUL_DN];
        end
      end
      else if (pcnt_q >= PULSE_N - ONE)
      begin
        pcnt_q <= ZERO;
        pnum_q <= pnum_q + 4'h1;
        if (pnum_q == `CSC_PULSE_NUM - 4'h1)
        begin
          up_q <= 1'b0;
          dn_q <= 1'b0;
        end
      end
      else
        pcnt_q <= pcnt_q + ONE;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  wire [5:0] cfg_lim = ctrl_q[`CSC_CTRL_LIMPIN] ? min6(INPUT_LIMIT_SETTING, CURRENT_LIMIT_PIN)
                                                : INPUT_LIMIT_SETTING;
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      BATTERY_SWITCH <= 1'b1;
      CONVERTER_EN   <= 1'b0;
      CURRENT_LIMIT_PIN_EFF       <= `CSC_LIM_100MA;
      CHG_REDUCE     <= 1'b0;
      TERM_DIS       <= 1'b0;
      TIMER_HALF     <= 1'b0;
    end
    else
    begin
      BATTERY_SWITCH <= (sw_q == SW_ON || sw_q == SW_DLY) && !TSHUT;
      CONVERTER_EN   <= !TSHUT && !INPUT_OVERVOLTAGE && !SYSTEM_OVERVOLTAGE;
      CURRENT_LIMIT_PIN_EFF       <= (run && pnum_q[0]) ? `CSC_LIM_100MA : cfg_lim;
      CHG_REDUCE     <= OVER_THERMAL_REGULATION_THRESHOLD;
      TERM_DIS       <= OVER_THERMAL_REGULATION_THRESHOLD;
      TIMER_HALF     <= OVER_THERMAL_REGULATION_THRESHOLD;
    end
  end

  // ********************************
  // Read data
  // ********************************
  always @(posedge MCLK)
  begin
    if (!RST_B)
      RDATA <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        `CSC_ADDR_CTRL:   RDATA <= {2'h0, ctrl_q[5], boost_q, 1'b0, ctrl_q[2:0]};
        `CSC_ADDR_PULSE:  RDATA <= {5'h00, dn_q, up_q, pen_q};
        `CSC_ADDR_STATUS: RDATA <= {5'h00, sw_q, OVER_THERMAL_REGULATION_THRESHOLD};
        `CSC_ADDR_FAULT:  RDATA <= {1'b0, f_lat_q, THERMISTOR_FAULT_FIELD};
        default:          RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end
endmodule

/* File: csc_chk.sv */
module csc_chk #(
  parameter INT_CYC = 8
) (
  // Clock and reset
  input wire       MCLK,
  input wire       RST_B,
  // Inputs
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       SRC_ID,
  input wire       VBUS_PRESENT,
  input wire       INPUT_OVERVOLTAGE,
  input wire       SYSTEM_OVERVOLTAGE,
  input wire       TSHUT,
  input wire       OVER_THERMAL_REGULATION_THRESHOLD,
  input wire [5:0] INPUT_LIMIT_SETTING,
  input wire [5:0] CURRENT_LIMIT_PIN,
  // Outputs
  input wire       HOST_INT_B,
  input wire       BATTERY_SWITCH,
  input wire       CONVERTER_EN,
  input wire [5:0] CURRENT_LIMIT_PIN_EFF,
  input wire       CHG_REDUCE,
  input wire       TERM_DIS,
  input wire       TIMER_HALF
);
  logic [15:0] lo_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // ********************
  // Low cycle counter
  // ********************
  always @(posedge MCLK)
  begin
    if (!RST_B || HOST_INT_B)
      lo_q <= 16'h0000;
    else
      lo_q <= lo_q + 16'h0001;
  end
  // ********************
  // Checks
  // ********************
  int_width_a: assert property ($rose(HOST_INT_B) |-> lo_q == INT_CYC)
    else $error("interrupt width wrong");
  event_int_a: assert property (SRC_ID && HOST_INT_B |=> !HOST_INT_B)
    else $error("event gave no interrupt");
  ov_stop_a: assert property (INPUT_OVERVOLTAGE |=> !CONVERTER_EN)
    else $error("overvoltage kept converter");
  sysov_stop_a: assert property (SYSTEM_OVERVOLTAGE |=> !CONVERTER_EN)
    else $error("system overvoltage kept converter");
  tshut_off_a: assert property (TSHUT |=> !CONVERTER_EN && !BATTERY_SWITCH)
    else $error("shutdown left power on");
  thermal_regulation_threshold_follow_a: assert property (1 |=> {CHG_REDUCE, TERM_DIS, TIMER_HALF} == {3{$past(OVER_THERMAL_REGULATION_THRESHOLD)}})
    else $error("regulation outputs wrong");
  ship_off_a: assert property (WR && ADDR == 4'h0 && WDATA[1:0] == 2'b01 && !VBUS_PRESENT
    |-> ##[1:3] !BATTERY_SWITCH)
    else $error("switch not opened");
  ship_exit_a: assert property ($rose(VBUS_PRESENT) && !TSHUT |-> ##[1:3] BATTERY_SWITCH)
    else $error("switch not closed");
  abort_lim_a: assert property (WR && ADDR == 4'h1 && !WDATA[0]
    |-> ##[1:2] (CURRENT_LIMIT_PIN_EFF == INPUT_LIMIT_SETTING || CURRENT_LIMIT_PIN_EFF == CURRENT_LIMIT_PIN))
    else $error("limit not restored");
  cover property ($rose(HOST_INT_B));
  cover property ($fell(BATTERY_SWITCH));
  cover property (CURRENT_LIMIT_PIN_EFF == 6'h00);
endmodule
bind csc_top csc_chk #(.INT_CYC(INT_CYC)) chk (.*);

/* File: csc_host.sv */
module csc_host (
  // Clock
  input  wire        clk,
  // Register port
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic       wr,
  output logic       rd,
  input  wire  [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wdata, wr, rd} = 14'h0000;
  task wr_reg(input [3:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task rd_reg(input [3:0] a, output [7:0] v);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  end
  endtask
  // Enable first, then one direction only
  task pump(input up);
  begin
    wr_reg(4'h1, 8'h01);
    wr_reg(4'h1, up ? 8'h03 : 8'h05);
  end
  endtask
endmodule

/* File: csc_top_tb.sv */
module csc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK = 1'b0;
  logic        RST_B = 1'b0;
  wire  [3:0]  ADDR;
  wire  [7:0]  WDATA;
  wire         WR, RD, HOST_INT_B, BATTERY_SWITCH, CONVERTER_EN, CHG_REDUCE, TERM_DIS, TIMER_HALF;
  wire  [7:0]  RDATA;
  wire  [5:0]  CURRENT_LIMIT_PIN_EFF;
  logic [3:0]  ev = 4'h0;
  wire         SRC_ID = ev[0];
  wire         GOOD_IN = ev[1];
  wire         IN_REMOVED = ev[2];
  wire         CHG_DONE = ev[3];
  logic        VBUS_PRESENT = 1'b0;
  logic        PUSH_BUTTON_INPUT_B = 1'b1;
  logic        INPUT_OVERVOLTAGE = 1'b0;
  logic        SYSTEM_OVERVOLTAGE = 1'b0;
  logic        TSHUT = 1'b0;
  logic        OVER_THERMAL_REGULATION_THRESHOLD = 1'b0;
  logic        OTHER_FAULT = 1'b0;
  logic        BOOST_MODE = 1'b0;
  logic [2:0]  THERMISTOR_FAULT_FIELD = 3'h0;
  logic [5:0]  INPUT_LIMIT_SETTING = 6'h01;
  logic [5:0]  CURRENT_LIMIT_PIN = 6'h00;
  logic [31:0] seed = 32'h122F5077;
  logic [7:0]  v;
  integer      bad_count = 0;
  integer      num_checks = 0;
  integer      lows, zeros, offs, i;
  always #2 MCLK = ~MCLK;
  csc_top #(.INT_CYC(8), .DEGL_CYC(4), .HOLD_CYC(20), .RSTOFF_CYC(10), .SMDLY_CYC(12), .PULSE_CYC(6)) uut (.*);
  csc_host host (.clk(MCLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));
  always @(negedge MCLK)
  begin
    lows = lows + !HOST_INT_B;
    zeros = zeros + (CURRENT_LIMIT_PIN_EFF == 6'h00);
    offs = offs + !BATTERY_SWITCH;
  end
  // ********************
  // Helpers
  // ********************
  function [31:0] rnd;
  begin
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed;
  end
  endfunction
  task w(input integer n);
    repeat (n) @(posedge MCLK);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #40000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  // ********************
  // Tests
  // ********************
  initial
  begin
    w(3);
    RST_B <= 1'b1;
    host.rd_reg(4'hF, v);
    chk(v, 8'h00, "unmapped");
    host.rd_reg(4'h0, v);
    chk({v, HOST_INT_B, BATTERY_SWITCH}, {8'h04, 2'b11}, "reset");
    for (i = 0; i < 4; i = i + 1)
    begin
      w(1);
      lows = 0;
      ev <= 4'h1 << i;
      w(1);
      ev <= 4'h0;
      w(3);
      ev <= 4'h1 << ((i + 1) % 4);
      w(1);
      ev <= 4'h0;
      w(14);
      chk(lows, 8, "merged pulse");
    end
    $display("events done");
    v = rnd();
    THERMISTOR_FAULT_FIELD <= v[2:0];
    lows = 0;
    INPUT_OVERVOLTAGE <= 1'b1;
    w(12);
    INPUT_OVERVOLTAGE <= 1'b0;
    OTHER_FAULT <= 1'b1;
    w(12);
    OTHER_FAULT <= 1'b0;
    chk(lows, 8, "fault pulses");
    host.rd_reg(4'h4, v);
    chk(v, {5'h09, THERMISTOR_FAULT_FIELD}, "latched read");
    w(1);
    THERMISTOR_FAULT_FIELD <= ~THERMISTOR_FAULT_FIELD;
    host.rd_reg(4'h4, v);
    chk(v, {5'h00, THERMISTOR_FAULT_FIELD}, "live read");
    w(1);
    lows = 0;
    TSHUT <= 1'b1;
    w(12);
    TSHUT <= 1'b0;
    host.rd_reg(4'h4, v);
    chk(v, {5'h02, THERMISTOR_FAULT_FIELD}, "shutdown code");
    chk(lows, 8, "shutdown pulse");
    host.wr_reg(4'h0, 8'h14);
    lows = 0;
    BOOST_MODE <= 1'b1;
    TSHUT <= 1'b1;
    w(12);
    chk(BATTERY_SWITCH, 1'b0, "boost shutdown switch");
    TSHUT <= 1'b0;
    w(3);
    BOOST_MODE <= 1'b0;
    host.rd_reg(4'h0, v);
    chk(v, 8'h04, "boost bit cleared");
    host.rd_reg(4'h4, v);
    chk(v, {5'h04, THERMISTOR_FAULT_FIELD}, "boost shutdown code");
    chk(lows, 8, "boost shutdown pulse");
    chk(BATTERY_SWITCH, 1'b1, "boost switch back");
    w(3);
    OVER_THERMAL_REGULATION_THRESHOLD <= 1'b1;
    SYSTEM_OVERVOLTAGE <= 1'b1;
    w(3);
    OVER_THERMAL_REGULATION_THRESHOLD <= 1'b0;
    SYSTEM_OVERVOLTAGE <= 1'b0;
    v = rnd();
    INPUT_LIMIT_SETTING <= v[5:0] | 6'h01;
    CURRENT_LIMIT_PIN <= {v[7:6], 4'h0};
    $display("faults done");
    for (i = 0; i < 2; i = i + 1)
    begin
      zeros = 0;
      host.pump(i == 0);
      host.rd_reg(4'h1, v);
      chk(v, i ? 8'h05 : 8'h03, "pulse busy");
      w(60);
      chk(zeros, 24, "low limit cycles");
      host.rd_reg(4'h1, v);
      chk({v, CURRENT_LIMIT_PIN_EFF}, {8'h01, INPUT_LIMIT_SETTING}, "pulse end");
    end
    host.pump(1'b1);
    w(8);
    host.wr_reg(4'h1, 8'h00);
    host.rd_reg(4'h1, v);
    chk({v, CURRENT_LIMIT_PIN_EFF}, {8'h00, INPUT_LIMIT_SETTING}, "abort");
    host.wr_reg(4'h1, 8'h04);
    host.rd_reg(4'h1, v);
    chk({v, CURRENT_LIMIT_PIN_EFF}, {8'h00, INPUT_LIMIT_SETTING}, "down ignored");
    host.wr_reg(4'h0, 8'h24);
    host.rd_reg(4'h0, v);
    chk(CURRENT_LIMIT_PIN_EFF, CURRENT_LIMIT_PIN < INPUT_LIMIT_SETTING ? CURRENT_LIMIT_PIN : INPUT_LIMIT_SETTING, "pin");
    $display("limits done");
    host.wr_reg(4'h0, 8'h07);
    host.rd_reg(4'h0, v);
    chk(BATTERY_SWITCH, 1'b1, "delay wait");
    w(14);
    for (i = 0; i < 3; i = i + 1)
    begin
      host.wr_reg(4'h0, 8'h05);
      host.rd_reg(4'h0, v);
      chk(BATTERY_SWITCH, 1'b0, "ship entry");
      w(1);
      if (i == 0)
        host.wr_reg(4'h0, 8'h04);
      else if (i == 1)
        VBUS_PRESENT <= 1'b1;
      else
        PUSH_BUTTON_INPUT_B <= 1'b0;
      w(10);
      host.rd_reg(4'h2, v);
      chk(BATTERY_SWITCH, 1'b1, "ship exit");
      w(1);
      VBUS_PRESENT <= 1'b0;
      PUSH_BUTTON_INPUT_B <= 1'b1;
      host.wr_reg(4'h0, 8'h04);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      host.wr_reg(4'h0, i ? 8'h04 : 8'h00);
      offs = 0;
      PUSH_BUTTON_INPUT_B <= 1'b0;
      w(30);
      PUSH_BUTTON_INPUT_B <= 1'b1;
      w(20);
      chk(offs, i ? 10 : 0, "button reset");
    end
    $display("switch done");
    wrap_up;
  end
endmodule
